// [src/esh_egress_shaper.sv]
// egress priority rate shaper for three switch ports, four queues each
//
// Notes on behaviour
// - Each port has its own pair of egress rate registers at 0x18/0x19, 0x28/0x29 and 0x38/0x39.
// - The first register holds the priority 1 code in bits 7-4 and the priority 0 code in bits 3-0.
// - The second register holds the priority 3 code in bits 7-4 and the priority 2 code in bits 3-0.
// - Code 0000 leaves a queue unrestricted and every rate register resets to zero.
// - Codes 0001 to 0111 cap a queue at 64, 128, 256, 512 kb/s, then 1, 2, 4 Mb/s.
// - Codes 1000 to 1111 cap a queue at 8, 16, 32, 48, 64, 72, 80, 88 Mb/s.
// - On a 10 Mb/s port any code faster than 10 Mb/s acts as 0000.
// - With the multiple queue option off only the priority 0 field limits, and only queue 0; queues 1 to 3 run unrestricted.
// - With the multiple queue option on, each queue is shaped on its own by its own field.
// - With the gap option set, 12 bytes per frame are added to the counted bytes.
// - With the preamble option set, 8 bytes per frame are added to the counted bytes.
`timescale 1ns/1ps
module esh_egress_shaper (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_valid,
	// per-port mode inputs
	input esh_pkg::esh_port_cfg_type [esh_pkg::NUM_PORTS-1:0] port_cfg,
	// queue heads, one frame offered per queue
	input wire logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0] q_valid,
	input wire logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0][esh_pkg::LEN_W-1:0] q_len,
	output logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0] q_pop,
	// transmit mac side
	output logic [esh_pkg::NUM_PORTS-1:0] mac_valid,
	input wire logic [esh_pkg::NUM_PORTS-1:0] mac_ready,
	output esh_pkg::esh_desc_type [esh_pkg::NUM_PORTS-1:0] mac_desc,
	// status
	output logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0] q_held
);
	import esh_pkg::*;

	// ==========================================================
	// helpers

	// address to register select, used by both write and read paths
	function automatic esh_reg_sel_type decode_addr(input logic [7:0] addr);
		esh_reg_sel_type sel;
		sel = '0;
		if (addr == P1_RATE_LOW_OFS) begin
			sel = '{hit: 1'b1, port: 2'd0, high: 1'b0};
		end else if (addr == P1_RATE_HIGH_OFS) begin
			sel = '{hit: 1'b1, port: 2'd0, high: 1'b1};
		end else if (addr == P2_RATE_LOW_OFS) begin
			sel = '{hit: 1'b1, port: 2'd1, high: 1'b0};
		end else if (addr == P2_RATE_HIGH_OFS) begin
			sel = '{hit: 1'b1, port: 2'd1, high: 1'b1};
		end else if (addr == P3_RATE_LOW_OFS) begin
			sel = '{hit: 1'b1, port: 2'd2, high: 1'b0};
		end else if (addr == P3_RATE_HIGH_OFS) begin
			sel = '{hit: 1'b1, port: 2'd2, high: 1'b1};
		end
		return sel;
	endfunction

	// rate code to kilobits per second; zero means no limit
	function automatic logic [16:0] code_to_kbps(input logic [3:0] code);
		logic [16:0] kbps;
		kbps = 17'h00000;
		case (code)
			4'h1: kbps = 17'd64;
			4'h2: kbps = 17'd128;
			4'h3: kbps = 17'd256;
			4'h4: kbps = 17'd512;
			4'h5: kbps = 17'd1000;
			4'h6: kbps = 17'd2000;
			4'h7: kbps = 17'd4000;
			4'h8: kbps = 17'd8000;
			4'h9: kbps = 17'd16000;
			4'hA: kbps = 17'd32000;
			4'hB: kbps = 17'd48000;
			4'hC: kbps = 17'd64000;
			4'hD: kbps = 17'd72000;
			4'hE: kbps = 17'd80000;
			4'hF: kbps = 17'd88000;
			default: kbps = 17'h00000;
		endcase
		return kbps;
	endfunction

	// pick one queue's field out of the register pair
	function automatic logic [3:0] field_code(input logic [7:0] low, input logic [7:0] high, input int q);
		logic [3:0] code;
		code = RATE_CODE_RESET;
		case (q)
			0: code = low[LOWER_FIELD_LSB +: 4];
			1: code = low[UPPER_FIELD_LSB +: 4];
			2: code = high[LOWER_FIELD_LSB +: 4];
			default: code = high[UPPER_FIELD_LSB +: 4];
		endcase
		return code;
	endfunction

	// ==========================================================
	// register file

	logic [7:0] rate_low_reg [NUM_PORTS];
	logic [7:0] rate_high_reg [NUM_PORTS];
	esh_reg_sel_type wr_sel;
	esh_reg_sel_type rd_sel;

	assign wr_sel = decode_addr(reg_addr);
	assign rd_sel = decode_addr(reg_addr);

	// writes to unmapped offsets are dropped
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				rate_low_reg[p] <= RATE_REG_RESET;
				rate_high_reg[p] <= RATE_REG_RESET;
			end
		end else if (reg_wr_en && wr_sel.hit) begin
			if (wr_sel.high) begin
				rate_high_reg[wr_sel.port] <= reg_wr_data;
			end else begin
				rate_low_reg[wr_sel.port] <= reg_wr_data;
			end
		end
	end

	// read data one clock after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rd_data <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en && rd_sel.hit) begin
				reg_rd_data <= rd_sel.high ? rate_high_reg[rd_sel.port] : rate_low_reg[rd_sel.port];
			end else if (reg_rd_en) begin
				reg_rd_data <= 8'h00;
			end
		end
	end

	// ==========================================================
	// per-port shaping

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic [NUM_QUEUES-1:0] eligible;
		logic [NUM_QUEUES-1:0] take;
		logic sel_valid;
		logic [1:0] sel_q;
		logic fifo_in_ready;
		logic grant;
		logic [11:0] overhead;
		esh_desc_type sel_desc;

		// gap and preamble bytes are counted as if sent on the wire
		always_comb begin
			overhead = 12'h000;
			if (port_cfg[p].include_gap_bytes) begin
				overhead = overhead + GAP_BYTES;
			end
			if (port_cfg[p].include_preamble_bytes) begin
				overhead = overhead + PREAMBLE_BYTES;
			end
		end

		for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
			logic [3:0] raw_code;
			logic [3:0] eff_code;
			logic [16:0] kbps;
			logic unlimited;
			logic [11:0] bytes;
			logic [31:0] cost;

			// effective code after the single-queue and 10 Mb/s clamps
			always_comb begin
				raw_code = field_code(rate_low_reg[p], rate_high_reg[p], q);
				eff_code = raw_code;
				if (!port_cfg[p].multi_queue_en && (q != 0)) begin
					eff_code = RATE_CODE_UNLIMITED;
				end
				if (port_cfg[p].speed_10 && (code_to_kbps(eff_code) > TEN_MBPS_KBPS)) begin
					eff_code = RATE_CODE_UNLIMITED;
				end
				kbps = code_to_kbps(eff_code);
				unlimited = (eff_code == RATE_CODE_UNLIMITED);
			end

			// frame cost in credit units
			assign bytes = 12'(q_len[p][q]) + overhead;
			assign cost = 32'(bytes) * BYTE_COST;
			assign take[q] = grant && (sel_q == 2'(q));

			// own bucket per queue, never shared
			esh_credit u_credit (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.unlimited(unlimited),
				.rate_kbps(kbps),
				.cost(cost),
				.take(take[q]),
				.eligible(eligible[q])
			);

			assign q_pop[p][q] = take[q];
			assign q_held[p][q] = q_valid[p][q] && !eligible[q];
		end

		// strict priority among queues whose bucket covers the head frame
		always_comb begin
			sel_valid = 1'b0;
			sel_q = 2'd0;
			for (int q = 0; q < NUM_QUEUES; q++) begin
				if (q_valid[p][q] && eligible[q]) begin
					sel_valid = 1'b1;
					sel_q = 2'(q);
				end
			end
		end

		// a full fifo stalls grants, so frames stay queued, never dropped
		assign grant = sel_valid && fifo_in_ready;
		assign sel_desc = '{queue: sel_q, len: q_len[p][sel_q]};

		esh_fifo #(
			.WIDTH($bits(esh_desc_type)),
			.DEPTH(FIFO_DEPTH)
		) u_fifo (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.in_valid(sel_valid),
			.in_ready(fifo_in_ready),
			.in_data(sel_desc),
			.out_valid(mac_valid[p]),
			.out_ready(mac_ready[p]),
			.out_data(mac_desc[p])
		);
	end

endmodule

// [src/esh_pkg.sv]
// shared constants and types for the egress priority rate shaper
package esh_pkg;

	// ==========================================================
	// structure
	localparam int NUM_PORTS = 3;
	localparam int NUM_QUEUES = 4;
	localparam int LEN_W = 11;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================
	// register offsets, one pair per port
	localparam logic [7:0] P1_RATE_LOW_OFS = 8'h18;
	localparam logic [7:0] P1_RATE_HIGH_OFS = 8'h19;
	localparam logic [7:0] P2_RATE_LOW_OFS = 8'h28;
	localparam logic [7:0] P2_RATE_HIGH_OFS = 8'h29;
	localparam logic [7:0] P3_RATE_LOW_OFS = 8'h38;
	localparam logic [7:0] P3_RATE_HIGH_OFS = 8'h39;

	// field positions inside each rate register
	localparam int UPPER_FIELD_LSB = 4;
	localparam int LOWER_FIELD_LSB = 0;
	localparam logic [3:0] RATE_CODE_RESET = 4'h0;
	localparam logic [7:0] RATE_REG_RESET = 8'h00;
	localparam logic [3:0] RATE_CODE_UNLIMITED = 4'h0;

	// ==========================================================
	// per-frame overhead and rate arithmetic
	localparam logic [11:0] GAP_BYTES = 12'h00C;
	localparam logic [11:0] PREAMBLE_BYTES = 12'h008;
	localparam int CLK_HZ = 40_000_000;
	localparam logic [16:0] TEN_MBPS_KBPS = 17'h02710;
	// credit unit is one kbps for one clock; a byte costs this many
	localparam logic [31:0] BYTE_COST = 32'(8 * CLK_HZ / 1000);
	localparam int MAX_BURST_BYTES = 4096;
	localparam logic [31:0] CREDIT_MAX = 32'(64'(BYTE_COST) * MAX_BURST_BYTES);

	// ==========================================================
	// types
	typedef struct packed {
		logic multi_queue_en;
		logic speed_10;
		logic include_gap_bytes;
		logic include_preamble_bytes;
	} esh_port_cfg_type;

	typedef struct packed {
		logic [1:0] queue;
		logic [LEN_W-1:0] len;
	} esh_desc_type;

	typedef struct packed {
		logic hit;
		logic [1:0] port;
		logic high;
	} esh_reg_sel_type;

endpackage

// [src/esh_fifo.sv]
// descriptor fifo between the shaper and the transmit mac
`timescale 1ns/1ps
module esh_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty
	assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	// storage, no reset needed on data
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// write pointer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	// read pointer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule

// [src/esh_credit.sv]
// byte credit bucket for one egress queue
`timescale 1ns/1ps
module esh_credit (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// rate selection
	input wire logic unlimited,
	input wire logic [16:0] rate_kbps,
	// frame at the queue head
	input wire logic [31:0] cost,
	input wire logic take,
	// status
	output logic eligible
);
	import esh_pkg::*;

	logic [31:0] credit_reg;
	logic [31:0] credit_next;
	logic [32:0] sum;
	logic [31:0] capped;

	// bucket refills by the rate each clock, capped at one burst
	always_comb begin
		sum = {1'b0, credit_reg} + 33'(rate_kbps);
		capped = (sum > 33'(CREDIT_MAX)) ? CREDIT_MAX : sum[31:0];
		if (unlimited) begin
			credit_next = CREDIT_MAX;
		end else if (take) begin
			credit_next = capped - cost;
		end else begin
			credit_next = capped;
		end
	end

	// frame waits in its queue until the bucket covers it
	assign eligible = unlimited || (credit_reg >= cost);

	// bucket state
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			credit_reg <= CREDIT_MAX;
		end else begin
			credit_reg <= credit_next;
		end
	end

endmodule

// [sim/esh_egress_shaper_asserts.sv]
// port-level checks for the egress shaper
`timescale 1ns/1ps
module esh_egress_shaper_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic reg_rd_valid,
	// queues and mac
	input wire logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0] q_valid,
	input wire logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0] q_pop,
	input wire logic [esh_pkg::NUM_PORTS-1:0][esh_pkg::NUM_QUEUES-1:0] q_held,
	input wire logic [esh_pkg::NUM_PORTS-1:0] mac_valid,
	input wire logic [esh_pkg::NUM_PORTS-1:0] mac_ready,
	input esh_pkg::esh_desc_type [esh_pkg::NUM_PORTS-1:0] mac_desc
);
	import esh_pkg::*;
	// ==========================================================
	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic mapped;
	// only the six rate registers return data
	assign mapped = reg_addr inside {P1_RATE_LOW_OFS, P1_RATE_HIGH_OFS, P2_RATE_LOW_OFS, P2_RATE_HIGH_OFS,
		P3_RATE_LOW_OFS, P3_RATE_HIGH_OFS};
	// a stalled descriptor on port 0 must not change under the mac
	sequence s_stalled;
		mac_valid[0] && !mac_ready[0];
	endsequence
	sequence s_kept;
		mac_valid[0] && $stable(mac_desc[0]);
	endsequence
	// ==========================================================
	// properties
	property p_rd_answer;
		reg_rd_en |=> reg_rd_valid;
	endproperty
	property p_rd_quiet;
		!reg_rd_en |=> !reg_rd_valid;
	endproperty
	property p_rd_unmapped;
		reg_rd_en && !mapped |=> reg_rd_data == 8'h00;
	endproperty
	property p_pop_valid;
		(q_pop & ~q_valid) == '0;
	endproperty
	property p_pop_single;
		$onehot0(q_pop[0]) && $onehot0(q_pop[1]) && $onehot0(q_pop[2]);
	endproperty
	property p_held_no_pop;
		(q_held & q_pop) == '0;
	endproperty
	property p_mac_stands;
		s_stalled |=> s_kept;
	endproperty
	property p_pop_reaches_mac;
		(|q_pop[0]) |=> mac_valid[0];
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray read answer");
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	a_pop_valid: assert property (p_pop_valid) else $error("pop without frame");
	a_pop_single: assert property (p_pop_single) else $error("two pops on a port");
	a_held_no_pop: assert property (p_held_no_pop) else $error("held frame popped");
	a_mac_stands: assert property (p_mac_stands) else $error("descriptor moved");
	a_pop_reaches_mac: assert property (p_pop_reaches_mac) else $error("pop lost");
endmodule

bind esh_egress_shaper esh_egress_shaper_asserts i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
	.q_valid(q_valid), .q_pop(q_pop), .q_held(q_held), .mac_valid(mac_valid), .mac_ready(mac_ready),
	.mac_desc(mac_desc));

// [sim/esh_mac_model.sv]
// transmit mac model taking descriptors from the shaper
`timescale 1ns/1ps
module esh_mac_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// stall request per port
	input wire logic [esh_pkg::NUM_PORTS-1:0] stall,
	// descriptor handshake
	input wire logic [esh_pkg::NUM_PORTS-1:0] mac_valid,
	output logic [esh_pkg::NUM_PORTS-1:0] mac_ready,
	input esh_pkg::esh_desc_type [esh_pkg::NUM_PORTS-1:0] mac_desc
);
	import esh_pkg::*;
	int taken [NUM_PORTS];
	esh_desc_type last [NUM_PORTS];
	// ready moves only with the stall request, just after an edge
	assign mac_ready = ~stall;
	// count and keep what each port hands over
	always_ff @(posedge clk_sys or negedge rst_b) begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (!rst_b) begin
				taken[i] <= 0;
			end else if (mac_valid[i] && mac_ready[i]) begin
				taken[i] <= taken[i] + 1;
				last[i] <= mac_desc[i];
			end
		end
	end
endmodule

// [sim/tb.sv]
// self-checking bench for the egress shaper
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %s", $time, m); end end
module tb;
	import esh_pkg::*;
	logic clk_sys;
	logic rst_b;
	logic [7:0] reg_addr;
	logic reg_wr_en;
	logic [7:0] reg_wr_data;
	logic reg_rd_en;
	logic [7:0] reg_rd_data;
	logic reg_rd_valid;
	esh_port_cfg_type [NUM_PORTS-1:0] port_cfg;
	logic [NUM_PORTS-1:0][NUM_QUEUES-1:0] q_valid, q_pop, q_held;
	logic [NUM_PORTS-1:0][NUM_QUEUES-1:0][LEN_W-1:0] q_len;
	logic [NUM_PORTS-1:0] mac_valid, mac_ready, stall;
	esh_desc_type [NUM_PORTS-1:0] mac_desc;
	int err_count;
	int n_compared;
	int kbps [16] = '{0, 64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000, 32000, 48000, 64000, 72000, 80000, 88000};
	logic [7:0] ofs [6] = '{8'h18, 8'h19, 8'h28, 8'h29, 8'h38, 8'h39};
	esh_egress_shaper i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.port_cfg(port_cfg), .q_valid(q_valid), .q_len(q_len), .q_pop(q_pop), .mac_valid(mac_valid),
		.mac_ready(mac_ready), .mac_desc(mac_desc), .q_held(q_held));
	esh_mac_model i_mac (.clk_sys(clk_sys), .rst_b(rst_b), .stall(stall), .mac_valid(mac_valid),
		.mac_ready(mac_ready), .mac_desc(mac_desc));
	// ==========================================================
	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// bus cycles, always launched 1 ns after the edge
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_rd_en = 1'b0;
		`CHK(reg_rd_valid, 1'b1, "no answer")
		`CHK(reg_rd_data, e, "read data")
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// offer 2000-byte frames on the masked queues, count pops per queue
	task automatic burst(int p, logic [3:0] m, int n, output int c[4]);
		c = '{0, 0, 0, 0};
		@(posedge clk_sys);
		#1;
		q_len[p] = {4{11'd2000}};
		q_valid[p] = m;
		repeat (n) begin
			@(negedge clk_sys);
			for (int q = 0; q < 4; q++) c[q] += int'(q_pop[p][q] === 1'b1);
		end
		@(posedge clk_sys);
		#1;
		q_valid[p] = '0;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// steady pop spacing of 64-byte frames once the full bucket is spent
	task automatic gap(int p, int q, int e);
		int run;
		int g;
		bit seen;
		run = 0;
		g = 0;
		seen = 0;
		q_len[p][q] = 11'd64;
		q_valid[p][q] = 1'b1;
		for (int n = 0; n < 30000 && g == 0; n++) begin
			@(negedge clk_sys);
			run++;
			if (q_pop[p][q] === 1'b1) begin
				if (seen) g = run;
				seen = seen || run > 1;
				run = 0;
			end
		end
		if (g == 0) begin
			err_count++;
			$display("mismatch %0t no steady spacing", $time);
			end_of_test();
		end
		`CHK(g inside {[e:e + 2]}, 1'b1, "spacing")
		// the pop just spent the bucket, so the next head frame must wait
		@(negedge clk_sys);
		`CHK(q_held[p][q], 1'b1, "held after pop")
		@(posedge clk_sys);
		#1;
		q_valid[p][q] = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		for (int i = 0; i < 6; i++) rd(ofs[i], 8'h00);
		for (int i = 0; i < 6; i++) wr(ofs[i], ofs[i] ^ 8'hA5);
		wr(8'h1A, 8'hFF);
		for (int i = 0; i < 6; i++) rd(ofs[i], ofs[i] ^ 8'hA5);
		rd(8'h1A, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wr(8'h19, {c[3:0], ~c[3:0]});
			rd(8'h19, {c[3:0], ~c[3:0]});
		end
		for (int i = 0; i < 6; i++) wr(ofs[i], 8'h00);
		$display("test regs done");
	endtask
	task automatic t_rates();
		for (int c = 7; c < 16; c++) begin
			wr(8'h28, {c[3:0], 4'h0});
			gap(1, 1, 64 * int'(BYTE_COST) / kbps[c]);
			wr(8'h28, 8'h00);
		end
		$display("test rates done");
	endtask
	task automatic t_overhead();
		wr(8'h38, 8'h0F);
		for (int k = 0; k < 4; k++) begin
			port_cfg[2].include_gap_bytes = k[1];
			port_cfg[2].include_preamble_bytes = k[0];
			gap(2, 0, (64 + 12 * k[1] + 8 * k[0]) * int'(BYTE_COST) / 88000);
		end
		port_cfg[2] = 4'b1000;
		wr(8'h38, 8'h00);
		$display("test overhead done");
	endtask
	// slow-port clamp, single queue mode and per-queue independence
	task automatic t_modes();
		int c [4];
		port_cfg[0].speed_10 = 1'b1;
		wr(8'h18, 8'h0F);
		burst(0, 4'b0001, 20, c);
		`CHK(c[0], 20, "fast code clamped")
		wr(8'h18, 8'h08);
		burst(0, 4'b0001, 20, c);
		`CHK(c[0], 2, "slow code kept")
		port_cfg[0] = 4'b0000;
		wr(8'h18, 8'h00);
		wr(8'h18, 8'hFF);
		burst(0, 4'b0010, 20, c);
		`CHK(c[1], 20, "upper queue free")
		`CHK(i_mac.last[0], esh_desc_type'({2'd1, 11'd2000}), "descriptor")
		burst(0, 4'b0001, 20, c);
		`CHK(c[0], 2, "queue 0 limited")
		port_cfg[0] = 4'b1000;
		wr(8'h39, 8'hF0);
		burst(2, 4'b1100, 20, c);
		`CHK(c[3], 2, "limited queue")
		`CHK(c[2], 18, "free queue")
		$display("test modes done");
	endtask
	// mac stalls: the fifo fills to its depth, then drains whole
	task automatic t_fifo();
		int c [4];
		int t0;
		t0 = i_mac.taken[1];
		stall[1] = 1'b1;
		burst(1, 4'b0001, 40, c);
		`CHK(c[0], FIFO_DEPTH, "fill depth")
		stall[1] = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1;
		`CHK(i_mac.taken[1] - t0, FIFO_DEPTH, "drained")
		$display("test fifo done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
		q_valid = '0;
		q_len = '0;
		stall = '0;
		port_cfg = {NUM_PORTS{4'b1000}};
		err_count = 0;
		n_compared = 0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		t_regs();
		t_rates();
		t_overhead();
		t_modes();
		t_fifo();
		end_of_test();
	end
endmodule
